// ==== verif/ccs_charge_ctrl_sva.sv ====
`timescale 1ns/10ps
// ****
// Checker on the charge control ports
// ****
module ccs_charge_ctrl_sva (
	input wire       ref_clk_in,
	input wire       nrst_in,
	input wire       adapter_present_in,
	input wire       usb_present_in,
	input wire       vin_above_bat_in,
	input wire       vin_above_reg_in,
	input wire       die_warm_in,
	input wire       die_over_hot_in,
	input wire       thermistor_sense_input_in_window_in,
	input wire       thermistor_sense_input_above_test_in,
	input wire       adapter_current_set_in,
	input wire       usb_current_select_valid_in,
	input wire       pass_enable_out,
	input wire       regulate_voltage_out,
	input wire       thermal_foldback_out,
	input wire [1:0] current_select_out,
	input wire       supply_usb_out,
	input wire       thermistor_sense_input_bias_en_out,
	input wire       thermistor_sense_input_pulldown_en_out,
	input wire       charge_status_one_oe_out,
	input wire       charge_status_two_oe_out,
	input wire       charge_status_one_o_out,
	input wire       charge_status_two_o_out,
	input wire       power_good_n_oe_out,
	input wire       power_good_n_o_out,
	input wire       timer_fault_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	// Supply gone or too close to the battery
	wire pwr_lost = !vin_above_bat_in || (!adapter_present_in && !usb_present_in);
	// Current-set input of the active source not usable
	wire prog_bad = adapter_present_in ? !adapter_current_set_in : !usb_current_select_valid_in;
	// Input valid but below regulation headroom
	wire pg_det = !pwr_lost && !vin_above_reg_in;
	// Three cycles cover the synchroniser and output register
	sequence s_lost;
		pwr_lost [*3];
	endsequence
	sequence s_pg_det;
		pg_det [*8];
	endsequence
	chk_no_drive_high: assert property (!charge_status_one_o_out && !charge_status_two_o_out && !power_good_n_o_out)
		else $error("open-drain output drives high");
	chk_pwr_down: assert property (s_lost |=> !pass_enable_out && !power_good_n_oe_out && !charge_status_one_oe_out)
		else $error("no power-down on lost supply");
	chk_thermistor_sense_input_susp: assert property ((!thermistor_sense_input_in_window_in && !thermistor_sense_input_above_test_in) [*3] |=> !pass_enable_out)
		else $error("charging outside thermistor window");
	chk_die_hot: assert property (die_over_hot_in [*3] |=> !pass_enable_out)
		else $error("charging with die over hot");
	chk_foldback_on: assert property (die_warm_in [*3] |=> thermal_foldback_out)
		else $error("no foldback with warm die");
	chk_prog_open: assert property ((prog_bad && !thermistor_sense_input_above_test_in) [*3] |=> !pass_enable_out)
		else $error("charging with current-set open");
	chk_adapter_pref: assert property (adapter_present_in [*3] |=> !pass_enable_out || (current_select_out == 2'h0 && !supply_usb_out))
		else $error("adapter not preferred");
	chk_status_code: assert property (charge_status_two_oe_out |-> charge_status_one_oe_out ? regulate_voltage_out : !pass_enable_out)
		else $error("status code inconsistent");
	chk_pulldown_on: assert property (thermistor_sense_input_pulldown_en_out |-> !thermistor_sense_input_bias_en_out && (!charge_status_one_oe_out || charge_status_two_oe_out))
		else $error("pull-down on in wrong state");
	chk_timer_fault: assert property (timer_fault_out |-> !pass_enable_out && !charge_status_one_oe_out && !charge_status_two_oe_out)
		else $error("timer fault outputs wrong");
	chk_pg_valid: assert property ((!pwr_lost && vin_above_reg_in) [*3] |=> power_good_n_oe_out)
		else $error("power-good not low");
	chk_pg_pulse: assert property (s_pg_det |=> ##[0:5] $changed(power_good_n_oe_out))
		else $error("power-good not pulsing");
endmodule // ccs_charge_ctrl_sva

bind ccs_charge_ctrl ccs_charge_ctrl_sva u_chk (.*);

// ==== verif/ccs_host_model.sv ====
`timescale 1ns/10ps
// ****
// Host side: pull-ups on the open-drain pins
// ****
module ccs_host_model (
	input  wire    ref_clk_in,
	input  wire    stat_one_oe_in,
	input  wire    stat_one_o_in,
	input  wire    stat_two_oe_in,
	input  wire    stat_two_o_in,
	input  wire    pg_oe_in,
	input  wire    pg_o_in,
	output wire    stat_one_pin_out,
	output wire    stat_two_pin_out,
	output wire    pg_pin_out,
	output integer pg_edges_out
);
	// Released pins float up to the pull-up level
	assign stat_one_pin_out = stat_one_oe_in ? stat_one_o_in : 1'h1;
	assign stat_two_pin_out = stat_two_oe_in ? stat_two_o_in : 1'h1;
	assign pg_pin_out       = pg_oe_in ? pg_o_in : 1'h1;
	logic pg_last = 1'h1; // Previous power-good level
	initial pg_edges_out = 0;
	// Count power-good level changes seen by the indicator
	always @(posedge ref_clk_in) begin
		if (pg_pin_out !== pg_last)
			pg_edges_out <= pg_edges_out + 1;
		pg_last <= pg_pin_out;
	end
endmodule // ccs_host_model

// ==== verif/tb_charge_state_status_logic.sv ====
`timescale 1ns/10ps
module tb_charge_state_status_logic;
	// ****
	// Stimulus, outputs and model state
	// ****
	logic ref_clk_in, nrst_in, adapter_present_in, usb_present_in, vin_above_bat_in, vin_above_reg_in;
	logic battery_present_in, bat_below_precharge_in, bat_at_reg_in, bat_below_recharge_in;
	logic current_below_term_in, die_warm_in, die_over_hot_in, die_cooled_in, thermistor_sense_input_in_window_in;
	logic thermistor_sense_input_above_test_in, adapter_current_set_in, usb_current_select_valid_in;
	logic usb_current_select_in, timer_enable_n_in;
	wire pass_enable_out, regulate_voltage_out, precharge_current_out, term_compare_en_out;
	wire thermal_foldback_out, supply_usb_out, thermistor_sense_input_bias_en_out, thermistor_sense_input_pulldown_en_out;
	wire charge_status_one_oe_out, charge_status_two_oe_out, charge_status_one_o_out;
	wire charge_status_two_o_out, power_good_n_oe_out, power_good_n_o_out, timer_fault_out;
	wire [1:0] current_select_out;
	wire s1_pin, s2_pin, pg_pin;
	integer pg_edges, m_st, i, sel;
	integer num_errors = 0;
	integer cmp_count = 0;
	// Model: 0 off, 1 standby, 2 charging, 3 complete, 4 fault, 5 test
	logic [5:0] exp_s1 = 6'h1B; // Status one pin per model state
	logic [5:0] exp_s2 = 6'h17; // Status two pin per model state
	logic [5:0] exp_pg = 6'h01; // Power-good pin per model state
	logic [5:0] exp_ps = 6'h24; // Pass device per model state
	ccs_charge_ctrl #(.SAFETY_CYC(200), .PG_HALF_CYC(4)) dut (.*);
	ccs_host_model u_host (.ref_clk_in(ref_clk_in), .stat_one_oe_in(charge_status_one_oe_out),
		.stat_one_o_in(charge_status_one_o_out), .stat_two_oe_in(charge_status_two_oe_out),
		.stat_two_o_in(charge_status_two_o_out), .pg_oe_in(power_good_n_oe_out), .pg_o_in(power_good_n_o_out),
		.stat_one_pin_out(s1_pin), .stat_two_pin_out(s2_pin), .pg_pin_out(pg_pin), .pg_edges_out(pg_edges));
	// 25 ns clock
	initial begin
		ref_clk_in = 1'h0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	// ****
	// Tasks
	// ****
	task wt(input integer n);
		repeat (n) @(negedge ref_clk_in);
	endtask
	task cmp(input logic [3:0] got, input logic [3:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Compare pins and pass device with the model state
	task chk_st(input integer st);
		m_st = st;
		cmp({s1_pin, s2_pin, pg_pin, pass_enable_out}, {exp_s1[m_st], exp_s2[m_st], exp_pg[m_st], exp_ps[m_st]});
	endtask
	task tend(input string s);
		$display("Test %s done, errors %0d", s, num_errors);
	endtask
	task tally_and_finish;
		$display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watchdog well past the expected run
	initial begin
		repeat (90000) @(posedge ref_clk_in);
		num_errors++;
		tally_and_finish;
	end
	// ****
	// Main sequence
	// ****
	initial begin
		{nrst_in, adapter_present_in, usb_present_in, vin_above_bat_in, vin_above_reg_in, battery_present_in} = 6'h00;
		{bat_below_precharge_in, bat_at_reg_in, bat_below_recharge_in, current_below_term_in} = 4'h0;
		{die_warm_in, die_over_hot_in, thermistor_sense_input_above_test_in, adapter_current_set_in} = 4'h0;
		{usb_current_select_valid_in, usb_current_select_in} = 2'h0;
		{die_cooled_in, thermistor_sense_input_in_window_in, timer_enable_n_in} = 3'h7;
		sel = $urandom(99);
		wt(20);
		nrst_in = 1'h1;
		adapter_present_in = 1'h1;
		vin_above_bat_in = 1'h1;
		vin_above_reg_in = 1'h1;
		wt(4);
		chk_st(1);
		cmp({thermistor_sense_input_pulldown_en_out, thermistor_sense_input_bias_en_out, 2'h0}, 4'h8);
		battery_present_in = 1'h1;
		adapter_current_set_in = 1'h1;
		bat_below_precharge_in = 1'h1;
		wt(4);
		chk_st(2);
		cmp({precharge_current_out, thermistor_sense_input_bias_en_out, 2'h0}, 4'hC);
		bat_below_precharge_in = 1'h0;
		wt(4);
		cmp({precharge_current_out, supply_usb_out, current_select_out}, 4'h0);
		tend("charge start");
		thermistor_sense_input_in_window_in = 1'h0;
		wt(4);
		chk_st(4);
		thermistor_sense_input_in_window_in = 1'h1;
		wt(4);
		chk_st(2);
		{die_warm_in, die_over_hot_in, die_cooled_in} = 3'h6;
		wt(4);
		cmp({thermal_foldback_out, pass_enable_out, s1_pin, s2_pin}, 4'h9);
		die_over_hot_in = 1'h0;
		wt(4);
		cmp({thermal_foldback_out, pass_enable_out, s1_pin, s2_pin}, 4'h9);
		{die_warm_in, die_cooled_in} = 2'h1;
		wt(4);
		chk_st(2);
		tend("thermal");
		bat_at_reg_in = 1'h1;
		current_below_term_in = 1'h1;
		wt(4);
		cmp({regulate_voltage_out, term_compare_en_out, pass_enable_out, s1_pin}, 4'hE);
		wt(20000);
		current_below_term_in = 1'h0;
		wt(1);
		current_below_term_in = 1'h1;
		wt(39990);
		chk_st(2);
		wt(20);
		chk_st(3);
		bat_below_recharge_in = 1'h1;
		wt(4);
		chk_st(2);
		{bat_below_recharge_in, bat_at_reg_in, current_below_term_in} = 3'h0;
		wt(4);
		tend("termination");
		timer_enable_n_in = 1'h0;
		wt(100);
		thermistor_sense_input_in_window_in = 1'h0;
		wt(200);
		chk_st(4);
		thermistor_sense_input_in_window_in = 1'h1;
		wt(80);
		chk_st(2);
		wt(30);
		chk_st(4);
		cmp({timer_fault_out, 3'h0}, 4'h8);
		battery_present_in = 1'h0;
		timer_enable_n_in = 1'h1;
		wt(4);
		chk_st(1);
		tend("timer");
		{adapter_present_in, usb_present_in, usb_current_select_valid_in, battery_present_in} = 4'h7;
		for (i = 0; i < 2; i++) begin
			usb_current_select_in = sel[0] ^ i[0];
			wt(4);
			chk_st(2);
			cmp({supply_usb_out, 1'h0, current_select_out}, {2'h2, usb_current_select_in ? 2'h2 : 2'h1});
		end
		adapter_present_in = 1'h1;
		wt(4);
		cmp({supply_usb_out, pass_enable_out, current_select_out}, 4'h4);
		adapter_present_in = 1'h0;
		usb_current_select_valid_in = 1'h0;
		wt(4);
		chk_st(1);
		usb_current_select_valid_in = 1'h1;
		wt(4);
		chk_st(2);
		tend("usb");
		battery_present_in = 1'h0;
		vin_above_reg_in = 1'h0;
		wt(4);
		i = pg_edges;
		wt(40);
		cmp({3'h0, (pg_edges - i) >= 8}, 4'h1);
		vin_above_reg_in = 1'h1;
		wt(4);
		{thermistor_sense_input_above_test_in, thermistor_sense_input_in_window_in} = 2'h2;
		wt(4);
		chk_st(5);
		cmp({regulate_voltage_out, thermistor_sense_input_pulldown_en_out, thermistor_sense_input_bias_en_out, 1'h0}, 4'hC);
		{thermistor_sense_input_above_test_in, thermistor_sense_input_in_window_in} = 2'h1;
		wt(4);
		chk_st(1);
		vin_above_bat_in = 1'h0;
		wt(4);
		chk_st(0);
		tend("test mode and power");
		tally_and_finish;
	end
endmodule // tb_charge_state_status_logic

// ==== verilog/ccs_charge_ctrl.v ====
`timescale 1ns/10ps
`include "ccs_consts.vh"
// Overview of operation
// [R1] Die hot lowers charge current, not stop
// [R2] Die over 150C suspends; resume after cooling
// [R3] Power-down below stop level or near battery
// [R4] Thermistor outside window suspends charging immediately
// [R5] Suspend opens pass device, holds timer
// [R6] Enter test mode: thermistor high, no battery
// [R7] Test mode regulates voltage, fast current limit
// [R8] Bias source off in shutdown, standby, test
// [R9] Pull-down on only in standby, test
// [R10] Leave test mode on release or power
// [R11] Status outputs only pull low or float
// [R12] Status encoding per charge state
// [R13] USB select low 100mA, high 500mA
// [R14] Power-good low when input valid, released shutdown
// [R15] Power-good pulses while detecting battery (code pulses it whenever input is below regulation, outside shutdown)
// [R16] Power-good only sinks, never sources
// [R17] Timer runs while enable input low
// [R18] Open current-set disables, reconnect restarts
// [R19] Precharge, end currents fixed fast ratios
// [R20] Termination needs 1 ms filtered low current
// [R21] Timer expiry in fast charge latches fault
// [R22] Complete restarts when battery below recharge
// [R23] Adapter supply preferred, USB otherwise
// [R24] Analog flags synchronised; outputs open-drain enables
module ccs_charge_ctrl #(
	parameter SAFETY_CYC  = `CCS_SAFETY_CYC,   // Safety timer length in cycles
	parameter PG_HALF_CYC = `CCS_PG_PULSE_CYC  // Power-good blink half period
) (
	input  wire       ref_clk_in,              // 40 MHz clock
	input  wire       nrst_in,                 // Synchronous reset, active low
	input  wire       adapter_present_in,      // Adapter above stop level
	input  wire       usb_present_in,          // USB above stop level
	input  wire       vin_above_bat_in,        // Input exceeds battery by 100 mV
	input  wire       vin_above_reg_in,        // Input above regulation plus 0.3 V
	input  wire       battery_present_in,      // Battery detected on output
	input  wire       bat_below_precharge_in,  // Battery below precharge threshold
	input  wire       bat_at_reg_in,           // Battery reached regulation voltage
	input  wire       bat_below_recharge_in,   // Battery below recharge threshold
	input  wire       current_below_term_in,   // Current below end-of-charge level
	input  wire       die_warm_in,             // Die at thermal regulation point
	input  wire       die_over_hot_in,         // Die above 150 C
	input  wire       die_cooled_in,           // Die cooled by about 10 C
	input  wire       thermistor_sense_input_in_window_in,      // Thermistor inside window
	input  wire       thermistor_sense_input_above_test_in,     // Thermistor above supply minus 100 mV
	input  wire       adapter_current_set_in,  // Adapter set resistor connected
	input  wire       usb_current_select_valid_in, // USB select pin driven
	input  wire       usb_current_select_in,   // USB select level
	input  wire       timer_enable_n_in,       // Safety timer enable, active low
	output reg        pass_enable_out,         // Pass transistor on
	output reg        regulate_voltage_out,    // Voltage loop active
	output reg        precharge_current_out,   // Use precharge ratio
	output reg        term_compare_en_out,     // End-of-charge comparator armed
	output reg        thermal_foldback_out,    // Fold current back for die heat
	output reg  [1:0] current_select_out,      // Current source code
	output reg        supply_usb_out,          // USB supply path chosen
	output reg        thermistor_sense_input_bias_en_out,       // Thermistor bias source on
	output reg        thermistor_sense_input_pulldown_en_out,   // Thermistor pull-down on
	output reg        charge_status_one_oe_out, // Status one pulls low
	output reg        charge_status_two_oe_out, // Status two pulls low
	output wire       charge_status_one_o_out, // Status one driven level
	output wire       charge_status_two_o_out, // Status two driven level
	output reg        power_good_n_oe_out,     // Power-good pulls low
	output wire       power_good_n_o_out,      // Power-good driven level
	output reg        timer_fault_out          // Timer fault flag
);
	// ************************************************************
	// Local state codes
	// ************************************************************
	localparam [9:0] ST_SD  = `CCS_ST_SHUTDOWN;   // Shutdown
	localparam [9:0] ST_SB  = `CCS_ST_STANDBY;    // Standby
	localparam [9:0] ST_PRE = `CCS_ST_PRECHARGE;  // Precharge
	localparam [9:0] ST_CC  = `CCS_ST_FASTCHG;    // Constant current
	localparam [9:0] ST_CV  = `CCS_ST_CONSTVOLT;  // Constant voltage
	localparam [9:0] ST_DN  = `CCS_ST_COMPLETE;   // Charge complete
	localparam [9:0] ST_TF  = `CCS_ST_TEMPFAULT;  // Thermistor suspend
	localparam [9:0] ST_XF  = `CCS_ST_TIMERFAULT; // Timer fault
	localparam [9:0] ST_LDO = `CCS_ST_TESTMODE;   // System test
	localparam [9:0] ST_DH  = `CCS_ST_DIEHOT;     // Die overtemperature suspend
	localparam [31:0] TERM_CYC = `CCS_TERM_FILT_CYC; // 1 ms filter length

	// ************************************************************
	// Input synchronisation
	// ************************************************************
	wire [19:0] raw_w;  // Raw asynchronous inputs
	wire [19:0] s_w;    // Synchronised inputs
	assign raw_w = {adapter_present_in, usb_present_in, vin_above_bat_in, vin_above_reg_in,
		battery_present_in, bat_below_precharge_in, bat_at_reg_in, bat_below_recharge_in,
		current_below_term_in, die_warm_in, die_over_hot_in, die_cooled_in,
		thermistor_sense_input_in_window_in, thermistor_sense_input_above_test_in, adapter_current_set_in,
		usb_current_select_valid_in, usb_current_select_in, timer_enable_n_in, 2'h0};

	ccs_sync2 #(.W(20)) u_sync ( // see [R24]
		.ref_clk_in (ref_clk_in),
		.async_in   (raw_w),
		.sync_out   (s_w)
	);

	wire ac_w    = s_w[19]; // Adapter present
	wire usb_w   = s_w[18]; // USB present
	wire abov_w  = s_w[17]; // Input above battery
	wire areg_w  = s_w[16]; // Input above regulation
	wire bat_w   = s_w[15]; // Battery present
	wire pre_w   = s_w[14]; // Below precharge
	wire atreg_w = s_w[13]; // At regulation
	wire rech_w  = s_w[12]; // Below recharge
	wire iterm_w = s_w[11]; // Current below end level
	wire warm_w  = s_w[10]; // Die warm
	wire hot_w   = s_w[9];  // Die over 150 C
	wire cool_w  = s_w[8];  // Die cooled
	wire twin_w  = s_w[7];  // Thermistor in window
	wire ttst_w  = s_w[6];  // Thermistor high for test
	wire adapter_current_set_input_w = s_w[5];  // Adapter resistor connected
	wire p2v_w   = s_w[4];  // USB select driven
	wire p2_w    = s_w[3];  // USB select level
	wire ten_n_w = s_w[2];  // Timer enable, active low

	// ************************************************************
	// Decode helpers
	// ************************************************************
	// Charging states that run the safety timer and check thermistor
	function is_charging;
		input [9:0] st;
		begin
			is_charging = (st == ST_PRE) || (st == ST_CC) || (st == ST_CV);
		end
	endfunction

	wire power_ok_w = (ac_w || usb_w) && abov_w;        // see [R3]
	wire use_usb_w  = !ac_w && usb_w;                   // see [R23]
	wire prog_ok_w  = use_usb_w ? p2v_w : adapter_current_set_input_w;      // see [R18]

	reg [9:0]  state_q, state_d;   // Charge state
	reg [31:0] timer_q, timer_d;   // Safety timer count
	reg [31:0] filt_q, filt_d;     // Termination filter count
	reg [31:0] blink_q;            // Power-good blink divider
	reg        blink_ph_q;         // Blink phase
	reg        hot_q, hot_d;       // Die-hot latch for hysteresis

	wire timer_run_w = !ten_n_w && is_charging(state_q) && !hot_q; // see [R17] see [R5]
	wire timer_exp_w = timer_run_w && (timer_q >= SAFETY_CYC - 1);
	wire term_ok_w   = (filt_q >= TERM_CYC - 1);                   // see [R20]

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always @* begin
		state_d = state_q;
		timer_d = timer_q;
		filt_d  = 32'h00000000;
		hot_d   = hot_q;
		// Die hysteresis: set above 150 C, clear after cooling
		if (hot_w) begin
			hot_d = 1'b1; // see [R2]
		end else if (cool_w) begin
			hot_d = 1'b0; // see [R2]
		end
		if (timer_run_w) begin
			timer_d = timer_q + 32'h00000001;
		end
		if ((state_q == ST_CV) && iterm_w && !hot_q) begin
			filt_d = filt_q + 32'h00000001; // see [R20]
		end
		if (!power_ok_w) begin
			state_d = ST_SD; // see [R3]
		end else begin
			case (state_q)
				ST_SD: begin
					if (ttst_w && !bat_w) state_d = ST_LDO;      // see [R6]
					else state_d = ST_SB;
				end
				ST_SB: begin
					if (ttst_w && !bat_w) state_d = ST_LDO;      // see [R6]
					else if (bat_w && prog_ok_w) begin
						timer_d = 32'h00000000;
						state_d = pre_w ? ST_PRE : ST_CC;
					end
				end
				ST_LDO: begin
					if (!ttst_w) state_d = ST_SB;                 // see [R10]
				end
				ST_PRE, ST_CC, ST_CV: begin
					if (!bat_w || !prog_ok_w) state_d = ST_SB;     // see [R18]
					else if (!twin_w) state_d = ST_TF;             // see [R4]
					else if (timer_exp_w) state_d = ST_XF;         // see [R21]
					else if ((state_q == ST_PRE) && !pre_w) begin
						state_d = ST_CC;
						timer_d = 32'h00000000;
					end else if ((state_q == ST_CC) && atreg_w) state_d = ST_CV;
					else if ((state_q == ST_CV) && term_ok_w) state_d = ST_DN;
				end
				ST_TF: begin
					// Timer held; resume at precharge if battery below precharge, else fast charge
					if (!bat_w || !prog_ok_w) state_d = ST_SB;
					else if (twin_w) state_d = pre_w ? ST_PRE : ST_CC; // see [R5]
				end
				ST_XF: begin
					if (!bat_w || !prog_ok_w) state_d = ST_SB;     // see [R21]
				end
				ST_DN: begin
					if (!bat_w || !prog_ok_w) state_d = ST_SB;
					else if (rech_w) begin
						timer_d = 32'h00000000;
						state_d = ST_CC;                           // see [R22]
					end
				end
				default: state_d = ST_SD;
			endcase
		end
	end

	// ************************************************************
	// State registers
	// ************************************************************
	always @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			state_q    <= ST_SD;
			timer_q    <= 32'h00000000;
			filt_q     <= 32'h00000000;
			hot_q      <= 1'b0;
			blink_q    <= 32'h00000000;
			blink_ph_q <= 1'b0;
		end else begin
			state_q <= state_d;
			timer_q <= timer_d;
			filt_q  <= filt_d;
			hot_q   <= hot_d;
			// Blink divider for power-good indication while input below regulation
			if (blink_q >= PG_HALF_CYC - 1) begin
				blink_q    <= 32'h00000000;
				blink_ph_q <= !blink_ph_q;
			end else begin
				blink_q <= blink_q + 32'h00000001;
			end
		end
	end

	// ************************************************************
	// Registered outputs
	// ************************************************************
	always @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			pass_enable_out          <= 1'b0;
			regulate_voltage_out     <= 1'b0;
			precharge_current_out    <= 1'b0;
			term_compare_en_out      <= 1'b0;
			thermal_foldback_out     <= 1'b0;
			current_select_out       <= `CCS_ISEL_ADAPTER;
			supply_usb_out           <= 1'b0;
			thermistor_sense_input_bias_en_out        <= 1'b0;
			thermistor_sense_input_pulldown_en_out    <= 1'b0;
			charge_status_one_oe_out <= 1'b0;
			charge_status_two_oe_out <= 1'b0;
			power_good_n_oe_out      <= 1'b0;
			timer_fault_out          <= 1'b0;
		end else begin
			// Pass device only in charging or test, never when die hot
			pass_enable_out <= (is_charging(state_d) || state_d == ST_LDO) && !hot_d;  // see [R5] see [R2]
			regulate_voltage_out  <= (state_d == ST_CV) || (state_d == ST_LDO);     // see [R7]
			precharge_current_out <= (state_d == ST_PRE);                           // see [R19]
			term_compare_en_out   <= (state_d == ST_CV);                            // see [R19]
			thermal_foldback_out  <= warm_w;                                        // see [R1]
			supply_usb_out        <= use_usb_w;                                     // see [R23]
			current_select_out    <= !use_usb_w ? `CCS_ISEL_ADAPTER :
				(p2_w ? `CCS_ISEL_USB_HIGH : `CCS_ISEL_USB_LOW);                     // see [R13]
			thermistor_sense_input_bias_en_out     <= !((state_d == ST_SD) || (state_d == ST_SB) ||
				(state_d == ST_LDO));                                                // see [R8]
			thermistor_sense_input_pulldown_en_out <= (state_d == ST_SB) || (state_d == ST_LDO);     // see [R9]
			charge_status_one_oe_out <= is_charging(state_d) || (state_d == ST_LDO); // see [R12]
			charge_status_two_oe_out <= (state_d == ST_DN) || (state_d == ST_LDO);   // see [R12]
			// Power good: released in shutdown, blink while input below regulation
			if (state_d == ST_SD) begin
				power_good_n_oe_out <= 1'b0;                                         // see [R14]
			end else if (!areg_w) begin
				power_good_n_oe_out <= blink_ph_q;                                   // see [R15]
			end else begin
				power_good_n_oe_out <= 1'b1;                                         // see [R14]
			end
			timer_fault_out <= (state_d == ST_XF);                                   // see [R21]
		end
	end

	// Open-drain pins only ever drive low
	assign charge_status_one_o_out = 1'b0; // see [R11]
	assign charge_status_two_o_out = 1'b0; // see [R11]
	assign power_good_n_o_out      = 1'b0; // see [R16]
endmodule // ccs_charge_ctrl

// ==== verilog/ccs_consts.vh ====
`ifndef CCS_CONSTS_VH
`define CCS_CONSTS_VH
// State codes, one-hot
`define CCS_ST_SHUTDOWN   10'h001
`define CCS_ST_STANDBY    10'h002
`define CCS_ST_PRECHARGE  10'h004
`define CCS_ST_FASTCHG    10'h008
`define CCS_ST_CONSTVOLT  10'h010
`define CCS_ST_COMPLETE   10'h020
`define CCS_ST_TEMPFAULT  10'h040
`define CCS_ST_TIMERFAULT 10'h080
`define CCS_ST_TESTMODE   10'h100
`define CCS_ST_DIEHOT     10'h200
`define CCS_STATE_W       10
// Clock and timing
`define CCS_CLK_HZ        40000000
`define CCS_TERM_FILT_US  1000
`define CCS_TERM_FILT_CYC ((`CCS_CLK_HZ / 1000000) * `CCS_TERM_FILT_US)
`define CCS_SAFETY_CYC    32'h00989680
`define CCS_PG_PULSE_CYC  32'h001312D0
// Current select codes
`define CCS_ISEL_ADAPTER  2'h0
`define CCS_ISEL_USB_LOW  2'h1
`define CCS_ISEL_USB_HIGH 2'h2
`endif

// ==== verilog/ccs_sync2.v ====
`timescale 1ns/10ps
// Two-stage synchroniser for a bus of asynchronous comparator levels
module ccs_sync2 #(
	parameter W = 1 // Number of bits
) (
	input  wire         ref_clk_in, // Block clock
	input  wire [W-1:0] async_in,   // Asynchronous levels
	output wire [W-1:0] sync_out    // Synchronised levels
);
	reg [W-1:0] meta_q; // First stage, read only by second
	reg [W-1:0] sync_q; // Second stage

	// ************************************************************
	// Synchroniser flops, no reset so no level leaks into reset
	// ************************************************************
	always @(posedge ref_clk_in) begin
		meta_q <= async_in;
		sync_q <= meta_q;
	end

	assign sync_out = sync_q;
endmodule // ccs_sync2
